/* File: rtl/dfl_pkg.sv */
// Shared constants, register map and types of the fault log manager.
// Assumes a single 40 MHz core clock and a plain strobe register port.
package dfl_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register port and map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_INT_STAT  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_INT_MASK  = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_LOG_IDX   = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_LOG_DATA  = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_LOG_COUNT = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_TIME      = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_DISP      = 8'h20;

	// Field positions
	localparam int CTRL_RESET_BIT  = 0;
	localparam int CTRL_ENABLE_BIT = 1;
	localparam int ST_DISP_BIT     = 0;
	localparam int ST_ENOK_BIT     = 1;
	localparam int ST_IND_LSB      = 8;
	localparam int ST_COND_LSB     = 16;
	localparam int INT_W           = 3;
	localparam int INT_FAULT       = 0;
	localparam int INT_ALARM       = 1;
	localparam int INT_INHIBIT     = 2;
	localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int STAMP_TICK_NS = 1000000;
	localparam int REPOST_NS     = 1000;
	localparam int STAMP_TICK_CYC = STAMP_TICK_NS / CLK_PERIOD_NS;
	localparam int REPOST_CYC =
		(REPOST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_W = $clog2(REPOST_CYC + 1);

	////////////////////////////////////////////////////////////////////////
	// Exception codes and log entries
	localparam int LOG_DEPTH = 128;
	localparam int STAMP_W   = 14;

	typedef enum logic [2:0] {
		CLS_RUNTIME, CLS_STARTUP, CLS_MODULE, CLS_MODWARN,
		CLS_INHIBIT, CLS_ALARM, CLS_PROTECT
	} dfl_class_t;
	typedef enum logic {ORG_STANDARD, ORG_MAKER} dfl_origin_t;
	typedef enum logic {SCOPE_AXIS, SCOPE_ALL} dfl_scope_t;
	typedef enum logic {SUF_FACTORY, SUF_USER} dfl_suffix_t;

	typedef struct packed {
		dfl_class_t  cls;
		dfl_origin_t origin;
		dfl_scope_t  scope;
		logic [3:0]  axis;
		dfl_suffix_t suffix;
		logic [7:0]  num;
	} dfl_code_t;

	typedef struct packed {
		dfl_code_t            code;
		logic [STAMP_W-1:0]   stamp;
	} dfl_entry_t;

	// Classes that carry a fault action and fault the axis
	function automatic logic dfl_is_fault(input dfl_code_t c);
		return c.cls == CLS_RUNTIME || c.cls == CLS_STARTUP ||
			c.cls == CLS_MODULE || c.cls == CLS_PROTECT;
	endfunction : dfl_is_fault

	// Whether a code concerns a given axis
	function automatic logic dfl_applies(input dfl_code_t c,
			input logic [3:0] a);
		return c.scope == SCOPE_ALL || c.cls == CLS_MODULE || c.axis == a;
	endfunction : dfl_applies

endpackage : dfl_pkg

/* File: rtl/dfl_fault_log.sv */
// Persistent ring of the newest fault entries, read back by age.
// Assumes at most one write per cycle; it has no erase input at all.
`timescale 1ns/100ps
module dfl_fault_log
	import dfl_pkg::*;
#(
	parameter int DEPTH = LOG_DEPTH
) (
	input  wire logic                       core_clk,
	input  wire logic                       nrst,
	input  wire logic                       wrEn,
	input  wire dfl_entry_t                 wrEntry,
	input  wire logic [$clog2(DEPTH)-1:0]   rdAge,
	output      dfl_entry_t                 rdEntry,
	output      logic [$clog2(DEPTH):0]     count
);
	localparam int PTR_W = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
		$error("dfl_fault_log: DEPTH must be a power of two");
	end

	typedef struct packed {
		dfl_entry_t [DEPTH-1:0] mem;
		logic [PTR_W-1:0]       wrPtr;
		logic [PTR_W:0]         count;
	} dfl_log_state_t;

	dfl_log_state_t st_reg;
	dfl_log_state_t st_next;
	logic [PTR_W-1:0] rdSlot;

	////////////////////////////////////////////////////////////////////////
	// Write side: the pointer wraps, so a full ring drops its oldest entry
	always_comb begin
		st_next = st_reg;
		if (wrEn) begin
			// [RQ7] ring entry write
			st_next.mem[st_reg.wrPtr] = wrEntry;
			st_next.wrPtr = st_reg.wrPtr + 1'b1;
			// [RQ16] overwrite oldest when full
			if (st_reg.count != (PTR_W+1)'(DEPTH))
				st_next.count = st_reg.count + 1'b1;
		end
	end

	// [RQ8] no clear path exists
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// Age 0 is the newest entry; ages past the fill level read as zero
	assign rdSlot  = st_reg.wrPtr - 1'b1 - rdAge;
	assign rdEntry = ({1'b0, rdAge} < st_reg.count) ?
		st_reg.mem[rdSlot] : '0;
	assign count   = st_reg.count;

endmodule : dfl_fault_log

/* File: rtl/dfl_fault_mgr.sv */
// Fault classification, display, action and logging for a servo module.
// Assumes condition inputs and their codes are synchronous to core_clk,
// and a controller issuing fault reset through the CTRL register.
//
// Notes on behaviour
// [RQ1] On detection: act, display, log with stamp
// [RQ2] Earliest arrived fault holds the display
// [RQ3] Reset clears display only for gone conditions; the code clears it for every source and reposts present ones
// [RQ4] Still present after reset: repost and relog
// [RQ5] Indication may clear; condition word stays faulted
// [RQ6] Controller judges fault from condition word only
// [RQ7] Log keeps newest 128 time-stamped entries
// [RQ8] Log cannot be erased from the module
// [RQ9] Runtime codes: standard/maker, one or all axes
// [RQ10] Module-wide class faults every axis
// [RQ11] Alarm classes only report, no action
// [RQ12] Inhibit condition blocks enabling while present
// [RQ13] Display suffix marks factory or user limit
// [RQ14] Travel limits are checked by the controller
// [RQ15] Protection function faults have their own class
// [RQ16] Full log overwrites its oldest entry
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/100ps
module dfl_fault_mgr
	import dfl_pkg::*;
#(
	parameter int NSRC     = 8,
	parameter int NAXES    = 2,
	parameter int TICK_CYC = STAMP_TICK_CYC
) (
	input  wire logic                  core_clk,
	input  wire logic                  nrst,
	input  wire logic [ADDR_W-1:0]     regAddr,
	input  wire logic [DATA_W-1:0]     regWdata,
	input  wire logic                  regWr,
	input  wire logic                  regRd,
	output      logic [DATA_W-1:0]     regRdata,
	input  wire logic [NSRC-1:0]       srcActive,
	input  wire dfl_code_t [NSRC-1:0]  srcCode,
	output      logic                  dispValid,
	output      dfl_code_t             dispCode,
	output      dfl_suffix_t           dispSuffix,
	output      logic [NAXES-1:0]      driveFaultIndication,
	output      logic [NAXES-1:0]      motionConditionWord,
	output      logic [NAXES-1:0]      faultAction,
	output      logic                  enableOk,
	output      logic                  irq
);
	localparam int RANK_W = $clog2(NSRC + 1);
	localparam int TICK_W = $clog2(TICK_CYC);
	localparam int IDX_W  = $clog2(LOG_DEPTH);
	localparam int SRC_W  = $clog2(NSRC);

	if (NAXES < 1 || NAXES > 8 || NSRC < 2 || NSRC > 16 || TICK_CYC < 2)
	begin : g_bad_param
		$error("dfl_fault_mgr: unsupported NAXES, NSRC or TICK_CYC");
	end

	typedef struct packed {
		logic [NSRC-1:0]              latched;
		logic [NSRC-1:0]              hold;
		logic [NSRC-1:0][RANK_W-1:0]  rank;
		logic [RANK_W-1:0]            nLatched;
		logic [HOLD_W-1:0]            holdCnt;
		logic [TICK_W-1:0]            tickCnt;
		logic [STAMP_W-1:0]           stamp;
		logic                         enReq;
		logic [INT_W-1:0]             intStat;
		logic [INT_W-1:0]             intMask;
		logic [IDX_W-1:0]             logIdx;
		logic [DATA_W-1:0]            rdata;
		logic                         dispValid;
		dfl_code_t                    dispCode;
		logic [NAXES-1:0]             faultInd;
		logic [NAXES-1:0]             condWord;
		logic                         enableOk;
	} dfl_state_t;

	dfl_state_t st_reg;
	dfl_state_t st_next;

	logic                 rstReq;
	logic [NSRC-1:0]      fltMask;
	logic [NSRC-1:0]      inhMask;
	logic [NSRC-1:0]      modMask;
	logic [NSRC-1:0]      cand;
	logic                 pick;
	logic [SRC_W-1:0]     pickIdx;
	dfl_code_t            pickCode;
	logic                 logWr;
	dfl_entry_t           logEntry;
	dfl_entry_t           logRdEntry;
	logic [IDX_W:0]       logCount;

	////////////////////////////////////////////////////////////////////////
	// Per-source class masks
	always_comb begin
		for (int i = 0; i < NSRC; i++) begin
			// [RQ15] protection class is a fault class
			fltMask[i] = dfl_is_fault(srcCode[i]);
			inhMask[i] = srcCode[i].cls == CLS_INHIBIT;
			modMask[i] = srcCode[i].cls == CLS_MODULE;
		end
	end

	// A fault reset is a write of one to the reset bit of CTRL
	assign rstReq = regWr && regAddr == OFF_CTRL &&
		regWdata[CTRL_RESET_BIT];

	////////////////////////////////////////////////////////////////////////
	// New arrivals: one per cycle, lowest source first, so the log never
	// needs two write ports; sources on repost hold wait out the delay
	always_comb begin
		cand    = srcActive & ~st_reg.latched;
		if (st_reg.holdCnt != '0)
			cand = cand & ~st_reg.hold;
		pick    = 1'b0;
		pickIdx = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (cand[i]) begin
				pick    = 1'b1;
				pickIdx = SRC_W'(i);
			end
		end
		// The reset cycle takes no arrival, so it sees a stable set
		if (rstReq)
			pick = 1'b0;
		pickCode = srcCode[pickIdx];
	end

	// [RQ1] log each posted fault with stamp
	assign logWr          = pick;
	assign logEntry.code  = pickCode;
	assign logEntry.stamp = st_reg.stamp;

	dfl_fault_log #(
		.DEPTH(LOG_DEPTH)
	) u_log (
		.core_clk (core_clk),
		.nrst     (nrst),
		.wrEn     (logWr),
		.wrEntry  (logEntry),
		.rdAge    (st_reg.logIdx),
		.rdEntry  (logRdEntry),
		.count    (logCount)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [INT_W-1:0]  evt;
		logic [RANK_W-1:0] best;
		logic              anyInh;
		evt    = '0;
		best   = '1;
		anyInh = 1'b0;
		st_next = st_reg;

		// Time stamp base: one-cycle tick enable from a divider
		if (st_reg.tickCnt == TICK_W'(TICK_CYC - 1)) begin
			st_next.tickCnt = '0;
			st_next.stamp   = st_reg.stamp + 1'b1;
		end else begin
			st_next.tickCnt = st_reg.tickCnt + 1'b1;
		end

		// Repost delay countdown; gone sources leave hold when it expires
		if (st_reg.holdCnt != '0)
			st_next.holdCnt = st_reg.holdCnt - 1'b1;
		else
			st_next.hold = st_reg.hold & srcActive;

		if (rstReq) begin
			// [RQ3] clear display on fault reset
			st_next.latched  = '0;
			st_next.nLatched = '0;
			// [RQ4] still active: hold then repost
			st_next.hold = st_reg.hold | (st_reg.latched & srcActive);
			if ((st_reg.latched & srcActive) != '0)
				st_next.holdCnt = HOLD_W'(REPOST_CYC);
		end else if (pick) begin
			// [RQ2] arrival rank orders the display
			st_next.latched[pickIdx] = 1'b1;
			st_next.hold[pickIdx]    = 1'b0;
			st_next.rank[pickIdx]    = st_reg.nLatched;
			st_next.nLatched         = st_reg.nLatched + 1'b1;
			// [RQ11] alarms only raise a report
			if (dfl_is_fault(pickCode))
				evt[INT_FAULT] = 1'b1;
			else if (pickCode.cls == CLS_INHIBIT)
				evt[INT_INHIBIT] = 1'b1;
			else
				evt[INT_ALARM] = 1'b1;
		end

		// [RQ2] lowest rank wins the display
		st_next.dispValid = 1'b0;
		st_next.dispCode  = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (st_next.latched[i] && st_next.rank[i] <= best) begin
				best              = st_next.rank[i];
				st_next.dispValid = 1'b1;
				st_next.dispCode  = srcCode[i];
			end
		end

		// Axis indications from the posted and held fault sources
		for (int a = 0; a < NAXES; a++) begin
			st_next.faultInd[a] = 1'b0;
			st_next.condWord[a] = 1'b0;
			for (int i = 0; i < NSRC; i++) begin
				// [RQ9] scope of a code per axis
				if (fltMask[i] && dfl_applies(srcCode[i], 4'(a))) begin
					// [RQ5] hold keeps condition word set
					st_next.faultInd[a] |= st_next.latched[i];
					st_next.condWord[a] |= st_next.latched[i] |
						st_next.hold[i];
				end
			end
		end

		// [RQ12] inhibit blocks enable while present
		anyInh = (srcActive & inhMask) != '0;
		st_next.enableOk = st_next.enReq && !anyInh &&
			st_next.condWord == '0;

		// Register writes; the log itself has no writable field
		if (regWr) begin
			case (regAddr)
				OFF_CTRL:     st_next.enReq = regWdata[CTRL_ENABLE_BIT];
				OFF_INT_MASK: st_next.intMask = regWdata[INT_W-1:0];
				OFF_LOG_IDX:  st_next.logIdx = regWdata[IDX_W-1:0];
				default:      ;
			endcase
		end
		// Sticky events; a new event beats a same-cycle clear
		if (regWr && regAddr == OFF_INT_STAT)
			st_next.intStat = st_reg.intStat & ~regWdata[INT_W-1:0];
		st_next.intStat = st_next.intStat | evt;
		if (regWr && regAddr == OFF_CTRL)
			st_next.enableOk = st_next.enableOk &&
				regWdata[CTRL_ENABLE_BIT];

		// Read data stand only in the cycle after the read strobe
		st_next.rdata = '0;
		if (regRd) begin
			case (regAddr)
				OFF_CTRL:
					st_next.rdata[CTRL_ENABLE_BIT] = st_reg.enReq;
				OFF_STATUS: begin
					st_next.rdata[ST_DISP_BIT] = st_reg.dispValid;
					st_next.rdata[ST_ENOK_BIT] = st_reg.enableOk;
					st_next.rdata[ST_IND_LSB +: NAXES]  = st_reg.faultInd;
					st_next.rdata[ST_COND_LSB +: NAXES] = st_reg.condWord;
				end
				OFF_INT_STAT:  st_next.rdata[INT_W-1:0] = st_reg.intStat;
				OFF_INT_MASK:  st_next.rdata[INT_W-1:0] = st_reg.intMask;
				OFF_LOG_IDX:   st_next.rdata[IDX_W-1:0] = st_reg.logIdx;
				OFF_LOG_DATA:  st_next.rdata = logRdEntry;
				OFF_LOG_COUNT: st_next.rdata[IDX_W:0] = logCount;
				OFF_TIME:      st_next.rdata[STAMP_W-1:0] = st_reg.stamp;
				OFF_DISP: begin
					st_next.rdata[$bits(dfl_code_t)-1:0] = st_reg.dispCode;
					st_next.rdata[DATA_W-1] = st_reg.dispValid;
				end
				default:       st_next.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg         <= '0;
			st_reg.intMask <= INT_MASK_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign regRdata             = st_reg.rdata;
	assign dispValid            = st_reg.dispValid;
	assign dispCode             = st_reg.dispCode;
	// [RQ13] suffix from limit source
	assign dispSuffix           = st_reg.dispCode.suffix;
	assign driveFaultIndication = st_reg.faultInd;
	assign motionConditionWord  = st_reg.condWord;
	// [RQ1] fault action follows faulted axes
	assign faultAction          = st_reg.condWord;
	assign enableOk             = st_reg.enableOk;
	assign irq                  = (st_reg.intStat & st_reg.intMask) != '0;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	chk_reset_clears_display: assert property ( // [RQ3]
		rstReq |=> !st_reg.dispValid && st_reg.latched == '0)
		else $error("display not cleared by fault reset");

	chk_repost_hold_set: assert property ( // [RQ4]
		rstReq && (st_reg.latched & srcActive) != '0 |=>
			st_reg.hold != '0 && st_reg.holdCnt == HOLD_W'(REPOST_CYC))
		else $error("active fault not held for repost");

	chk_cond_word_kept: assert property ( // [RQ5]
		rstReq && (st_reg.latched & srcActive & fltMask) != '0 &&
			st_reg.condWord != '0 |=> ##1 st_reg.condWord != '0)
		else $error("condition word dropped during repost delay");

	chk_display_stable: assert property ( // [RQ2]
		st_reg.dispValid && !rstReq && $stable(srcCode) |=>
			$stable(st_reg.dispCode))
		else $error("later fault displaced earlier one");

	chk_alarm_no_action: assert property ( // [RQ11]
		faultAction != '0 |->
			$past((st_next.latched | st_next.hold) & fltMask) != '0)
		else $error("fault action without fault class source");

	chk_inhibit_blocks: assert property ( // [RQ12]
		(srcActive & inhMask) != '0 |=> !enableOk)
		else $error("enabled while inhibit present");

	chk_log_grows: assert property ( // [RQ7]
		logWr && logCount < (IDX_W+1)'(LOG_DEPTH) |=>
			logCount == $past(logCount) + 1'b1)
		else $error("log entry not added");

	chk_log_never_shrinks: assert property ( // [RQ8]
		logCount >= $past(logCount))
		else $error("log entries lost");

	chk_log_full_wrap: assert property ( // [RQ16]
		logWr && logCount == (IDX_W+1)'(LOG_DEPTH) |=>
			logCount == (IDX_W+1)'(LOG_DEPTH))
		else $error("full log did not wrap");

	chk_fault_event_flag: assert property ( // [RQ1]
		logWr && dfl_is_fault(pickCode) |=> st_reg.intStat[INT_FAULT])
		else $error("fault posting did not flag event");

	chk_module_all_axes: assert property ( // [RQ10]
		(st_reg.latched & modMask) != '0 && $stable(srcCode) |->
			&st_reg.faultInd)
		else $error("module fault not applied to every axis");

endmodule : dfl_fault_mgr

/* File: tb/dfl_ctrl_model.sv */
// Controller-side model: owns the register port and judges axis faults.
// Assumes one core clock and a register slave that never stalls.
`timescale 1ns/100ps
module dfl_ctrl_model
	import dfl_pkg::*;
#(
	parameter int NAXES = 2
) (
	input  wire logic              core_clk,
	output      logic [ADDR_W-1:0] regAddr,
	output      logic [DATA_W-1:0] regWdata,
	output      logic              regWr,
	output      logic              regRd,
	input  wire logic [DATA_W-1:0] regRdata,
	input  wire logic [NAXES-1:0]  motionConditionWord,
	output      logic [NAXES-1:0]  axisFaulted
);
	////////////////////////////////////////////////////////////////////////
	// Idle bus from time zero
	initial begin
		regAddr = '0;
		regWdata = '0;
		regWr = 1'b0;
		regRd = 1'b0;
	end

	// travel limits judged here
	// The manager has no travel-limit code, so the controller owns it
	// condition word decides
	// Indication may read clear during a repost, so it is never used
	assign axisFaulted = motionConditionWord;

	// One-cycle write strobe, launched just after an edge
	task automatic wr(input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] d);
		@(posedge core_clk);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge core_clk);
		regWr    <= 1'b0;
	endtask : wr

	// Read strobe; data stands only in the following cycle
	task automatic rd(input logic [ADDR_W-1:0] a,
			output logic [DATA_W-1:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge core_clk);
		regRd   <= 1'b0;
		#1;
		d = regRdata;
	endtask : rd
endmodule : dfl_ctrl_model

/* File: tb/tb_top.sv */
// Self-checking bench for the fault log manager.
// Assumes the controller model drives every register access.
`timescale 1ns/100ps
module tb_top
	import dfl_pkg::*;
;
	localparam int NS = 4;
	localparam int NA = 2;
	typedef struct packed {
		dfl_code_t  code;
		logic [1:0] act;
		logic [2:0] intb;
	} dfl_row_t;

	logic                 core_clk;
	logic                 nrst;
	logic [ADDR_W-1:0]    regAddr;
	logic [DATA_W-1:0]    regWdata;
	logic                 regWr;
	logic                 regRd;
	logic [DATA_W-1:0]    regRdata;
	logic [NS-1:0]        srcActive;
	dfl_code_t [NS-1:0]   srcCode;
	logic                 dispValid;
	dfl_code_t            dispCode;
	dfl_suffix_t          dispSuffix;
	logic [NA-1:0]        driveFaultIndication;
	logic [NA-1:0]        motionConditionWord;
	logic [NA-1:0]        faultAction;
	logic                 enableOk;
	logic                 irq;
	logic [NA-1:0]        axisFaulted;
	int                   checks;
	int                   badCount;
	dfl_row_t             rows [8];

	////////////////////////////////////////////////////////////////////////
	// Design, with a short stamp tick to keep the run brief
	dfl_fault_mgr #(.NSRC(NS), .NAXES(NA), .TICK_CYC(4)) dut (
		.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .srcActive(srcActive), .srcCode(srcCode),
		.dispValid(dispValid), .dispCode(dispCode),
		.dispSuffix(dispSuffix),
		.driveFaultIndication(driveFaultIndication),
		.motionConditionWord(motionConditionWord),
		.faultAction(faultAction), .enableOk(enableOk), .irq(irq));

	// Controller model on the register port
	dfl_ctrl_model #(.NAXES(NA)) ctl (
		.core_clk(core_clk), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.motionConditionWord(motionConditionWord),
		.axisFaulted(axisFaulted));

	// 40 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic dfl_code_t mk(dfl_class_t c, dfl_origin_t o,
			dfl_scope_t s, logic [3:0] a, dfl_suffix_t f);
		return '{cls: c, origin: o, scope: s, axis: a, suffix: f,
			num: 8'h10};
	endfunction : mk

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			badCount++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", checks, badCount);
		if (badCount == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	// Bounded wait on the display flag; a hang ends the run
	task automatic wait_disp(input logic v);
		for (int n = 0; n < 80 && dispValid !== v; n++) begin
			@(posedge core_clk);
			#1;
		end
		if (dispValid !== v) begin
			badCount++;
			report_and_stop();
		end
	endtask : wait_disp

	// Drop every condition, then reset faults with enable kept
	task automatic clear_all();
		@(posedge core_clk);
		srcActive <= '0;
		ctl.wr(OFF_CTRL, 32'h3);
		wait_disp(1'b0);
	endtask : clear_all

	task automatic raise(input int i, input dfl_code_t c);
		@(posedge core_clk);
		srcCode[i]   <= c;
		srcActive[i] <= 1'b1;
		wait_disp(1'b1);
	endtask : raise

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		dfl_row_t    r;
		logic [31:0] d;
		logic [31:0] cnt;
		checks = 0;
		badCount = 0;
		nrst = 1'b0;
		srcActive = '0;
		srcCode = '0;
		rows[0] = '{mk(CLS_RUNTIME, ORG_STANDARD, SCOPE_AXIS, 4'h1,
			SUF_FACTORY), 2'h2, 3'h1};
		rows[1] = '{mk(CLS_RUNTIME, ORG_MAKER, SCOPE_ALL, 4'h0,
			SUF_USER), 2'h3, 3'h1};
		rows[2] = '{mk(CLS_STARTUP, ORG_STANDARD, SCOPE_AXIS, 4'h0,
			SUF_USER), 2'h1, 3'h1};
		rows[3] = '{mk(CLS_MODULE, ORG_STANDARD, SCOPE_AXIS, 4'h0,
			SUF_FACTORY), 2'h3, 3'h1};
		rows[4] = '{mk(CLS_MODWARN, ORG_STANDARD, SCOPE_AXIS, 4'h1,
			SUF_FACTORY), 2'h0, 3'h2};
		rows[5] = '{mk(CLS_INHIBIT, ORG_MAKER, SCOPE_AXIS, 4'h1,
			SUF_USER), 2'h0, 3'h4};
		rows[6] = '{mk(CLS_ALARM, ORG_MAKER, SCOPE_AXIS, 4'h0,
			SUF_FACTORY), 2'h0, 3'h2};
		rows[7] = '{mk(CLS_PROTECT, ORG_STANDARD, SCOPE_AXIS, 4'h1,
			SUF_USER), 2'h2, 3'h1};
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		// Reset values and an unmapped read
		ctl.rd(OFF_INT_MASK, d);
		chk(d, 32'h0);
		ctl.rd(OFF_STATUS, d);
		chk(d, 32'h0);
		ctl.rd(8'hfc, d);
		chk(d, 32'h0);
		$display("test reset done");
		// Class table; mask passes fault and inhibit interrupts only
		ctl.wr(OFF_CTRL, 32'h2);
		ctl.wr(OFF_INT_MASK, 32'h5);
		foreach (rows[i]) begin
			r = rows[i];
			raise(0, r.code);
			repeat (2) @(posedge core_clk);
			#1;
			chk(32'(dispCode), 32'(r.code));
			chk(32'(dispSuffix), 32'(r.code.suffix));
			chk(32'(faultAction), 32'(r.act));
			chk(32'(motionConditionWord), 32'(r.act));
			chk(32'(enableOk),
				32'(r.act == 2'h0 && r.code.cls != CLS_INHIBIT));
			ctl.rd(OFF_INT_STAT, d);
			chk(d, 32'(r.intb));
			chk(32'(irq), 32'(|(r.intb & 3'h5)));
			ctl.wr(OFF_INT_STAT, 32'h7);
			#1;
			chk(32'(irq), 32'h0);
			clear_all();
			chk(32'(motionConditionWord), 32'h0);
		end
		ctl.rd(OFF_LOG_COUNT, d);
		chk(d, 32'h8);
		$display("test classes done");
		// Earlier arrival keeps the display against a lower index
		raise(2, rows[7].code);
		raise(1, rows[0].code);
		repeat (3) @(posedge core_clk);
		#1;
		chk(32'(dispCode), 32'(rows[7].code));
		clear_all();
		$display("test order done");
		// Reset while the condition stays: hold, then repost and relog
		ctl.rd(OFF_LOG_COUNT, cnt);
		raise(3, rows[3].code);
		ctl.wr(OFF_CTRL, 32'h3);
		repeat (2) @(posedge core_clk);
		#1;
		chk(32'(dispValid), 32'h0);
		chk(32'(driveFaultIndication), 32'h0);
		chk(32'(axisFaulted), 32'h3);
		wait_disp(1'b1);
		chk(32'(driveFaultIndication), 32'h3);
		ctl.rd(OFF_LOG_COUNT, d);
		chk(d, cnt + 32'h2);
		clear_all();
		$display("test hold done");
		// Writes to the log registers must not erase anything
		ctl.wr(OFF_LOG_COUNT, 32'h0);
		ctl.wr(OFF_LOG_DATA, 32'h0);
		ctl.rd(OFF_LOG_COUNT, d);
		chk(d, cnt + 32'h2);
		$display("test erase done");
		// Overfill the log; oldest entries give way
		r = rows[0];
		for (int i = 0; i < 130; i++) begin
			r.code.num = 8'(i);
			raise(0, r.code);
			clear_all();
		end
		ctl.rd(OFF_LOG_COUNT, d);
		chk(d, 32'h80);
		ctl.wr(OFF_LOG_IDX, 32'h0);
		ctl.rd(OFF_LOG_DATA, d);
		chk(32'(d[31:14]), 32'(r.code));
		r.code.num = 8'h2;
		ctl.wr(OFF_LOG_IDX, 32'h7f);
		ctl.rd(OFF_LOG_DATA, d);
		chk(32'(d[31:14]), 32'(r.code));
		$display("test wrap done");
		report_and_stop();
	end
endmodule : tb_top
